//--- hdl/pms_core.sv
// Purpose: Mode select, fetch/execute sequencing, status pins, clock outputs, register
//          pairing, interrupt service and private emulation-ROM access of the processor.
// Assumes: Instruction bus and ROM data are on core_clk; pins are synchronised here.
// Notes:   One instruction cycle is one period of the synchronised crystal input.
//
// Function
// RULE_01 - High mode-select pin gives emulation mode; low or open gives native mode.
// RULE_02 - Fetch/execute indicator is low while executing, high while fetching.
// RULE_03 - Fetch/execute indicator floats whenever the test input is low.
// RULE_04 - Spare output three also floats while test input is low.
// RULE_05 - Core clock output is single phase, 50% duty, crystal frequency.
// RULE_06 - System clock output is a buffered copy of the core clock output.
// RULE_07 - Native instructions complete in two cycles: one fetch, one execute.
// RULE_08 - Sixteen vectored interrupt levels are serviced strictly in priority order.
// RULE_09 - Twenty 16-bit registers pair into ten 32-bit registers for any operation.
// RULE_10 - Each emulated opcode runs its own native macro from an 8K x 16 ROM.
// RULE_11 - Only the processor reaches the emulation ROM; no outside path exists.
// RULE_12 - With test input high, indicator and spare output drive their normal values.

`timescale 1ns/10ps

module pms_core
   import pms_pkg::*;
#(
   parameter logic [PMS_OP_W-1:0] ESCAPE_OP = PMS_ESCAPE_DEF
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   input  wire logic                      isa_mode_select,
   input  wire logic                      test_mode_n,
   input  wire logic                      crystal_drive_input,
   input  wire logic [PMS_NEXT_IRQ-1:0]   irq_ext,
   input  wire logic [PMS_NINT_IRQ-1:0]   irq_int,
   input  wire logic                      instr_ready,
   input  wire logic [PMS_WORD_W-1:0]     instr_word,
   input  wire logic [PMS_WORD_W-1:0]     rom_data,
   input  wire pms_rf_wr_t                rf_wr,
   input  wire pms_rf_rd_t                rf_rd,
   output logic                           core_clock_output,
   output logic                           buffered_system_clock,
   output logic                           fetch_execute_indicator_o,
   output logic                           fetch_execute_indicator_oe,
   output logic                           spare_output_three_o,
   output logic                           spare_output_three_oe,
   output logic                           emu_mode,
   output logic                           instr_fetch,
   output logic [PMS_WORD_W-1:0]          exec_word,
   output logic                           exec_strobe,
   output logic                           rom_en,
   output logic [PMS_ROM_AW-1:0]          rom_addr,
   output logic                           irq_ack,
   output logic [PMS_LVL_W-1:0]           irq_level,
   output logic [2*PMS_WORD_W-1:0]        rf_rd_data
);

   pms_state_t                q;
   pms_state_t                d;
   logic                      tick;
   logic                      src_ready;
   logic                      pend_valid;
   logic [PMS_LVL_W-1:0]      pend_lvl;
   logic [PMS_NLVL-1:0]       irq_req;

   // ************************************************************
   // Crystal phase and interrupt requests
   // ************************************************************
   // Rising edge of the synchronised crystal marks the start of each instruction cycle.
   assign tick      = q.xtal_sy[1] & ~q.xtal_sy[2];
   assign src_ready = q.in_macro | instr_ready;
   assign irq_req   = {q.irq_sy2, irq_int};

   pms_irq_prio #(
      .NLVL       (PMS_NLVL)
   ) u_irq (
      .core_clk   (core_clk),
      .rst        (rst),
      .req        (irq_req),
      .take       (q.irq_ack),
      .take_lvl   (q.irq_lvl),
      .pend_valid (pend_valid),
      .pend_lvl   (pend_lvl)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d          = q;
      d.mode_sy  = {q.mode_sy[0], isa_mode_select};
      d.test_sy  = {q.test_sy[0], test_mode_n};
      d.xtal_sy  = {q.xtal_sy[1:0], crystal_drive_input};
      d.irq_sy1  = irq_ext;
      d.irq_sy2  = q.irq_sy1;
      d.exec_stb = 1'b0;
      d.irq_ack  = 1'b0;

      // The outputs follow the crystal level, so duty and frequency are the crystal's own.
      d.core_clk_o = q.xtal_sy[1];   // see RULE_05
      d.sys_clk_o  = q.core_clk_o;   // see RULE_06

      if (tick) begin
         case (q.seq)
            PMS_FETCH: begin
               if (src_ready) begin
                  d.seq       = PMS_EXEC; // see RULE_07
                  d.fetch_req = 1'b0;
                  d.rom_en    = 1'b0;
                  if (q.in_macro) begin
                     d.exec_word = rom_data; // see RULE_10
                     d.exec_stb  = 1'b1;
                     if (rom_data[PMS_WORD_W-1 -: 4] == PMS_RET_NIBBLE) begin
                        d.in_macro = 1'b0;
                     end else begin
                        d.step = q.step + PMS_STEP_W'(1);
                     end
                  end else begin
                     if (q.emu && !q.escape) begin
                        d.op   = instr_word[PMS_WORD_W-1 -: PMS_OP_W];
                        d.step = '0;
                        // The escape opcode hands the next bus word to the native machine.
                        if (instr_word[PMS_WORD_W-1 -: PMS_OP_W] == ESCAPE_OP) begin
                           d.escape = 1'b1;
                        end else begin
                           d.in_macro = 1'b1; // see RULE_10
                        end
                     end else begin
                        d.escape    = 1'b0;
                        d.exec_word = instr_word;
                        d.exec_stb  = 1'b1;
                     end
                     // Interrupts are only taken at instruction-bus fetches, never while a macro runs from the ROM.
                     if (pend_valid) begin
                        d.irq_ack = 1'b1; // see RULE_08
                        d.irq_lvl = pend_lvl;
                     end
                  end
               end
            end
            PMS_EXEC: begin
               d.seq = PMS_FETCH;
               // The mode pin is sampled only at instruction boundaries.
               if (!d.in_macro && !d.escape) begin
                  d.emu = q.mode_sy[1]; // see RULE_01
               end
               d.fetch_req = ~d.in_macro;
               // The ROM address comes only from the sequencer, never from a bus.
               d.rom_en    = d.in_macro;  // see RULE_11
               d.rom_addr  = {d.op, d.step};
            end
            default: begin
               d.seq = PMS_FETCH;
            end
         endcase
      end

      d.fei.o    = (d.seq == PMS_FETCH); // see RULE_02
      d.fei.oe   = q.test_sy[1];         // see RULE_03 see RULE_12
      d.spare.o  = PMS_SPARE_VALUE;
      d.spare.oe = q.test_sy[1];         // see RULE_04 see RULE_12

      // Pairs are formed from an even register (upper half) and the next odd one.
      if (rf_wr.en) begin
         if (rf_wr.pair) begin
            if (rf_wr.idx < PMS_RIDX_W'(PMS_NPAIR)) begin
               d.regs[{rf_wr.idx[PMS_PIDX_W-1:0], 1'b0}] = rf_wr.data[2*PMS_WORD_W-1 -: PMS_WORD_W];
               d.regs[{rf_wr.idx[PMS_PIDX_W-1:0], 1'b1}] = rf_wr.data[PMS_WORD_W-1:0]; // see RULE_09
            end
         end else if (rf_wr.idx < PMS_RIDX_W'(PMS_NREG)) begin
            d.regs[rf_wr.idx] = rf_wr.data[PMS_WORD_W-1:0];
         end
      end
      d.rd_data = '0;
      if (rf_rd.pair) begin
         if (rf_rd.idx < PMS_RIDX_W'(PMS_NPAIR)) begin
            d.rd_data = {q.regs[{rf_rd.idx[PMS_PIDX_W-1:0], 1'b0}],
                         q.regs[{rf_rd.idx[PMS_PIDX_W-1:0], 1'b1}]}; // see RULE_09
         end
      end else if (rf_rd.idx < PMS_RIDX_W'(PMS_NREG)) begin
         d.rd_data = {{PMS_WORD_W{1'b0}}, q.regs[rf_rd.idx]};
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         q           <= '0;
         q.seq       <= PMS_FETCH;
         q.fei.o     <= PMS_FEI_RST;
         q.fetch_req <= PMS_FETCH_RST;
      end else begin
         q <= d;
      end
   end

   assign core_clock_output          = q.core_clk_o;
   assign buffered_system_clock      = q.sys_clk_o;
   assign fetch_execute_indicator_o  = q.fei.o;
   assign fetch_execute_indicator_oe = q.fei.oe;
   assign spare_output_three_o       = q.spare.o;
   assign spare_output_three_oe      = q.spare.oe;
   assign emu_mode                   = q.emu;
   assign instr_fetch                = q.fetch_req;
   assign exec_word                  = q.exec_word;
   assign exec_strobe                = q.exec_stb;
   assign rom_en                     = q.rom_en;
   assign rom_addr                   = q.rom_addr;
   assign irq_ack                    = q.irq_ack;
   assign irq_level                  = q.irq_lvl;
   assign rf_rd_data                 = q.rd_data;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_native_take;
      tick && q.seq == PMS_FETCH && !q.in_macro && !q.emu && instr_ready;
   endsequence

   sequence s_exec_then_fetch;
      (q.seq == PMS_EXEC && !fetch_execute_indicator_o) ##[1:32] q.seq == PMS_FETCH;
   endsequence

   AST_MODE_SAMPLE: assert property (tick && q.seq == PMS_EXEC && !d.in_macro && !d.escape
                                      |=> emu_mode == $past(q.mode_sy[1])) // see RULE_01
      else $error("Mode did not follow the mode-select pin at the boundary.");

   AST_FEI_LEVEL: assert property (q.fei.oe |-> fetch_execute_indicator_o == (q.seq == PMS_FETCH)) // see RULE_02
      else $error("Fetch/execute indicator disagrees with the sequencer state.");

   AST_FEI_FLOAT: assert property (!q.test_sy[1] |=> !fetch_execute_indicator_oe) // see RULE_03
      else $error("Fetch/execute indicator driven in test mode.");

   AST_SPARE_FLOAT: assert property (!q.test_sy[1] |=> !spare_output_three_oe) // see RULE_04
      else $error("Spare output three driven in test mode.");

   AST_DRIVE_NORMAL: assert property (q.test_sy[1] ##1 q.test_sy[1]
                                      |-> fetch_execute_indicator_oe && spare_output_three_oe) // see RULE_12
      else $error("Status outputs not driven while test input is high.");

   AST_CLK_FOLLOW: assert property ($rose(q.xtal_sy[1]) |=> core_clock_output ##1 buffered_system_clock) // see RULE_05 see RULE_06
      else $error("Clock outputs did not follow the crystal input.");

   AST_TWO_CYCLE: assert property (s_native_take |=> s_exec_then_fetch) // see RULE_07
      else $error("Native instruction did not finish in fetch plus one execute cycle.");

   AST_PAIR_RW: assert property (rf_wr.en && rf_wr.pair && rf_wr.idx < PMS_RIDX_W'(PMS_NPAIR)
                                 |=> q.regs[{$past(rf_wr.idx[3:0]), 1'b0}]
                                 == $past(rf_wr.data[31:16])) // see RULE_09
      else $error("Paired write did not land in the even register.");

   AST_ROM_PRIVATE: assert property (rom_en |-> emu_mode && rom_addr == {q.op, q.step}) // see RULE_10 see RULE_11
      else $error("Emulation ROM accessed outside an emulated macro.");

endmodule : pms_core

//--- hdl/pms_pkg.sv
// Purpose: Shared constants and carrier types of the processor mode and status block.
// Assumes: One core clock; every pin input is synchronised inside the block.
// Notes:   Offsets, widths, reset values and cycle counts live here only.

package pms_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int PMS_WORD_W   = 16;
   localparam int PMS_NREG     = 20;
   localparam int PMS_NPAIR    = 10;
   localparam int PMS_NLVL     = 16;
   localparam int PMS_NEXT_IRQ = 10;
   localparam int PMS_NINT_IRQ = 6;
   localparam int PMS_LVL_W    = 4;
   localparam int PMS_RIDX_W   = 5;
   localparam int PMS_PIDX_W   = 4;
   localparam int PMS_OP_W     = 8;
   localparam int PMS_STEP_W   = 5;
   localparam int PMS_ROM_AW   = 13;
   localparam int PMS_SYNC_N   = 2;

   // ************************************************************
   // Encodings and reset values
   // ************************************************************
   localparam logic [3:0]         PMS_RET_NIBBLE   = 4'hF;
   localparam logic [PMS_OP_W-1:0] PMS_ESCAPE_DEF  = 8'hFF;
   localparam logic               PMS_FEI_RST      = 1'b1;
   localparam logic               PMS_SPARE_VALUE  = 1'b0;
   localparam logic               PMS_FETCH_RST    = 1'b1;
   localparam int                 PMS_EXEC_CYCLES  = 2;

   typedef enum logic [1:0] {
      PMS_FETCH = 2'b01,
      PMS_EXEC  = 2'b10
   } pms_seq_t;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic o;
      logic oe;
   } pms_pin_t;

   typedef struct packed {
      logic                   en;
      logic                   pair;
      logic [PMS_RIDX_W-1:0]  idx;
      logic [2*PMS_WORD_W-1:0] data;
   } pms_rf_wr_t;

   typedef struct packed {
      logic                  pair;
      logic [PMS_RIDX_W-1:0] idx;
   } pms_rf_rd_t;

   typedef struct packed {
      logic [PMS_SYNC_N-1:0]              mode_sy;
      logic [PMS_SYNC_N-1:0]              test_sy;
      logic [PMS_SYNC_N:0]                xtal_sy;
      logic [PMS_NEXT_IRQ-1:0]            irq_sy1;
      logic [PMS_NEXT_IRQ-1:0]            irq_sy2;
      pms_seq_t                           seq;
      logic                               emu;
      logic                               in_macro;
      logic                               escape;
      logic [PMS_OP_W-1:0]                op;
      logic [PMS_STEP_W-1:0]              step;
      logic [PMS_WORD_W-1:0]              exec_word;
      logic                               exec_stb;
      logic                               fetch_req;
      logic                               rom_en;
      logic [PMS_ROM_AW-1:0]              rom_addr;
      logic                               irq_ack;
      logic [PMS_LVL_W-1:0]               irq_lvl;
      logic                               core_clk_o;
      logic                               sys_clk_o;
      pms_pin_t                           fei;
      pms_pin_t                           spare;
      logic [PMS_NREG-1:0][PMS_WORD_W-1:0] regs;
      logic [2*PMS_WORD_W-1:0]            rd_data;
   } pms_state_t;

   typedef struct packed {
      logic [PMS_NLVL-1:0] pend;
   } pms_irq_state_t;

endpackage : pms_pkg

//--- hdl/pms_irq_prio.sv
// Purpose: Sticky pending latch and fixed-priority selector for sixteen interrupt levels.
// Assumes: Requests are already on the core clock; level 0 is the most urgent.
// Notes:   A request in the cycle of its own acknowledge keeps the level pending.

`timescale 1ns/10ps

module pms_irq_prio
   import pms_pkg::*;
#(
   parameter int NLVL = PMS_NLVL
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [NLVL-1:0]      req,
   input  wire logic                 take,
   input  wire logic [PMS_LVL_W-1:0] take_lvl,
   output logic                      pend_valid,
   output logic [PMS_LVL_W-1:0]      pend_lvl
);

   pms_irq_state_t q;
   pms_irq_state_t d;
   logic [NLVL-1:0] pend_nxt;

   // ************************************************************
   // Per-level latch
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NLVL; gi++) begin : g_lvl
         assign pend_nxt[gi] = req[gi] |
            (q.pend[gi] & ~(take & (take_lvl == PMS_LVL_W'(gi)))); // see RULE_08
      end
   endgenerate

   always_comb begin
      d            = q;
      d.pend       = pend_nxt;
      pend_valid   = 1'b0;
      pend_lvl     = '0;
      // Scan from the least urgent level so the most urgent one wins.
      for (int i = NLVL - 1; i >= 0; i--) begin
         if (q.pend[i]) begin
            pend_valid = 1'b1;
            pend_lvl   = PMS_LVL_W'(i); // see RULE_08
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // The level was chosen one cycle before the acknowledge, so judge it against that view.
   AST_IRQ_PRIORITY: assert property (take
      |-> ($past(q.pend) & ((NLVL'(1) << take_lvl) - NLVL'(1))) == '0) // see RULE_08
      else $error("Interrupt taken while a more urgent level was pending.");

endmodule : pms_irq_prio

//--- testbench/pms_board_model.sv
// Purpose: Board-side model: crystal source, instruction memory and private emulation ROM.
// Assumes: The crystal half period is HALF core cycles, far slower than the core clock.
// Notes:   Released lines show the inverse of their last value, never a held copy.

`timescale 1ns/10ps

module pms_board_model
   import pms_pkg::*;
#(
   parameter int HALF = 5
) (
   input  wire logic                  core_clk,
   input  wire logic                  bus_on,
   input  wire logic [PMS_WORD_W-1:0] bus_word,
   input  wire logic                  rom_en,
   input  wire logic [PMS_ROM_AW-1:0] rom_addr,
   output logic                       crystal,
   output logic                       instr_ready,
   output logic [PMS_WORD_W-1:0]      instr_word,
   output logic [PMS_WORD_W-1:0]      rom_data
);
   logic [PMS_WORD_W-1:0] rom_mem [2**PMS_ROM_AW];
   int                    div;

   // Step 2 of every macro carries the return marker, so each macro is three words.
   initial begin
      crystal = 1'b0;
      instr_ready = 1'b0;
      instr_word = 16'h0000;
      rom_data = 16'h0000;
      div = 0;
      for (int a = 0; a < 2**PMS_ROM_AW; a++) begin
         rom_mem[a] = {(a[4:0] == 5'h02) ? 4'hF : 4'h3, a[11:0]};
      end
   end

   always @(posedge core_clk) begin
      div <= #1 (div == HALF - 1) ? 0 : div + 1;
      if (div == HALF - 1) begin
         crystal <= #1 ~crystal;
      end
      instr_ready <= #1 bus_on;
      instr_word  <= #1 bus_on ? bus_word : ~instr_word;
      // The ROM has no port but the processor's own enable and address.
      rom_data    <= #1 rom_en ? rom_mem[rom_addr] : ~rom_data;
   end
endmodule : pms_board_model

//--- testbench/processor_mode_status_pins_bench.sv
// Purpose: Self-checking bench of the processor mode and status block.
// Assumes: Board model makes the crystal at ten core cycles a period.
// Notes:   Inputs change 1 ns after the rising edge; outputs are read there too.

`timescale 1ns/10ps

module processor_mode_status_pins_bench import pms_pkg::*;;
   localparam int HALF_P = 5;

   logic                   core_clk, rst, isa_mode_select, test_mode_n, crystal;
   logic [PMS_NEXT_IRQ-1:0] irq_ext;
   logic [PMS_NINT_IRQ-1:0] irq_int;
   logic                   instr_ready, bus_on, rom_en, exec_strobe, emu_mode, instr_fetch;
   logic [PMS_WORD_W-1:0]  instr_word, rom_data, bus_word, exec_word;
   pms_rf_wr_t             rf_wr;
   pms_rf_rd_t             rf_rd;
   logic                   core_clock_output, buffered_system_clock;
   logic                   fei_o, fei_oe, spare_o, spare_oe;
   logic [PMS_ROM_AW-1:0]  rom_addr;
   logic                   irq_ack;
   logic [PMS_LVL_W-1:0]   irq_level;
   logic [31:0]            rf_rd_data;
   int                     error_cnt, comparisons;
   wire                    fei_pin = fei_oe ? fei_o : 1'bz;
   wire                    spare_pin = spare_oe ? spare_o : 1'bz;

   pms_core dut_u (.core_clk(core_clk), .rst(rst), .isa_mode_select(isa_mode_select),
      .test_mode_n(test_mode_n), .crystal_drive_input(crystal), .irq_ext(irq_ext),
      .irq_int(irq_int), .instr_ready(instr_ready), .instr_word(instr_word),
      .rom_data(rom_data), .rf_wr(rf_wr), .rf_rd(rf_rd),
      .core_clock_output(core_clock_output), .buffered_system_clock(buffered_system_clock),
      .fetch_execute_indicator_o(fei_o), .fetch_execute_indicator_oe(fei_oe),
      .spare_output_three_o(spare_o), .spare_output_three_oe(spare_oe),
      .emu_mode(emu_mode), .instr_fetch(instr_fetch), .exec_word(exec_word),
      .exec_strobe(exec_strobe),
      .rom_en(rom_en), .rom_addr(rom_addr), .irq_ack(irq_ack), .irq_level(irq_level),
      .rf_rd_data(rf_rd_data));

   pms_board_model #(.HALF(HALF_P)) board_u (.core_clk(core_clk), .bus_on(bus_on),
      .bus_word(bus_word), .rom_en(rom_en), .rom_addr(rom_addr), .crystal(crystal),
      .instr_ready(instr_ready), .instr_word(instr_word), .rom_data(rom_data));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic chk_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic step(input int n);
      repeat (n) begin
         @(posedge core_clk);
         #1;
      end
   endtask : step

   task automatic wait_strobe(output int n);
      n = 0;
      step(1);
      while (exec_strobe !== 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      chk_bit("exec_strobe", 1'b1, exec_strobe);
   endtask : wait_strobe

   // Writes are back to back, so the enable is lowered by the caller.
   task automatic reg_wr(input logic p, input logic [4:0] i, input logic [31:0] d);
      rf_wr = '{en: 1'b1, pair: p, idx: i, data: d};
      step(1);
   endtask : reg_wr

   task automatic reg_rd(input string what, input logic p, input logic [4:0] i,
                         input logic [31:0] exp);
      rf_rd = '{pair: p, idx: i};
      step(2);
      chk_word(what, exp, rf_rd_data);
   endtask : reg_rd

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_pins;
      chk_bit("fei_pin", 1'b1, fei_pin);
      chk_bit("spare_pin", PMS_SPARE_VALUE, spare_pin);
      test_mode_n = 1'b0;
      step(4);
      chk_bit("fei_pin", 1'bz, fei_pin);
      chk_bit("spare_pin", 1'bz, spare_pin);
      test_mode_n = 1'b1;
      step(4);
      chk_bit("fei_pin", 1'b1, fei_pin);
      chk_bit("spare_pin", PMS_SPARE_VALUE, spare_pin);
      $display("test pins done");
   endtask : t_pins

   // Forty samples cover exactly four periods whatever the starting phase.
   task automatic t_clocks;
      int   hi, rises, bad;
      logic prev;
      hi = 0;
      rises = 0;
      bad = 0;
      prev = core_clock_output;
      repeat (8 * HALF_P) begin
         step(1);
         hi += (core_clock_output === 1'b1);
         rises += (core_clock_output === 1'b1 && prev === 1'b0);
         bad += (buffered_system_clock !== prev);
         prev = core_clock_output;
      end
      chk_word("clk_high", 4 * HALF_P, hi);
      chk_word("clk_rises", 4, rises);
      chk_word("buffered_system_clock_lag", 0, bad);
      $display("test clocks done");
   endtask : t_clocks

   task automatic t_regs;
      reg_wr(1'b0, 5'h13, 32'h0000_0BAD);
      reg_wr(1'b1, 5'h03, 32'hA5C3_1E7F);
      reg_wr(1'b1, 5'h0A, 32'hFFFF_FFFF);
      rf_wr = '0;
      reg_rd("reg6", 1'b0, 5'h06, 32'h0000_A5C3);
      reg_rd("reg7", 1'b0, 5'h07, 32'h0000_1E7F);
      reg_rd("pair3", 1'b1, 5'h03, 32'hA5C3_1E7F);
      reg_rd("reg19", 1'b0, 5'h13, 32'h0000_0BAD);
      $display("test regs done");
   endtask : t_regs

   task automatic t_native;
      int n;
      bus_word = 16'h1234;
      bus_on = 1'b1;
      wait_strobe(n);
      chk_word("exec_word", 32'h0000_1234, {16'h0, exec_word});
      chk_bit("fei_pin", 1'b0, fei_pin);
      chk_bit("instr_fetch", 1'b0, instr_fetch);
      n = 0;
      while (fei_o === 1'b0 && n < 100) begin
         step(1);
         n++;
      end
      chk_word("exec_len", 2 * HALF_P, n);
      chk_bit("instr_fetch", 1'b1, instr_fetch);
      chk_bit("fei_pin", 1'b1, fei_pin);
      while (exec_strobe !== 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      chk_word("instr_len", 4 * HALF_P, n);
      chk_bit("rom_en", 1'b0, rom_en);
      bus_on = 1'b0;
      $display("test native done");
   endtask : t_native

   // Requests are raised together and must be acknowledged most urgent first.
   task automatic t_irq;
      int          k, n;
      logic [31:0] lv [3];
      bus_on = 1'b1;
      irq_int = 6'h14;
      irq_ext = 10'h001;
      k = 0;
      n = 0;
      while (k < 3 && n < 300) begin
         step(1);
         n++;
         if (n == 3) begin
            irq_int = '0;
            irq_ext = '0;
         end
         if (irq_ack === 1'b1) begin
            lv[k] = {28'h0, irq_level};
            k++;
         end
      end
      chk_word("irq_first", 32'h2, lv[0]);
      chk_word("irq_second", 32'h4, lv[1]);
      chk_word("irq_third", 32'h6, lv[2]);
      bus_on = 1'b0;
      $display("test irq done");
   endtask : t_irq

   task automatic t_emu;
      int n;
      isa_mode_select = 1'b1;
      bus_word = 16'h1234;
      bus_on = 1'b1;
      n = 0;
      while ((emu_mode !== 1'b1 || rom_en !== 1'b1) && n < 200) begin
         step(1);
         n++;
      end
      chk_bit("emu_mode", 1'b1, emu_mode);
      chk_word("rom_addr", 32'h0000_0240, {19'h0, rom_addr});
      for (int k = 0; k < 3; k++) begin
         wait_strobe(n);
         chk_word("macro_word", (k == 2) ? 32'hF242 : 32'h3240 + k, {16'h0, exec_word});
      end
      // An escape opcode hands the following bus word straight to the native machine.
      bus_word = 16'hFF5A;
      wait_strobe(n);
      chk_word("escape_word", 32'h0000_FF5A, {16'h0, exec_word});
      chk_bit("rom_en", 1'b0, rom_en);
      isa_mode_select = 1'b0;
      bus_on = 1'b0;
      $display("test emu done");
   endtask : t_emu

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   initial begin
      #50000;
      error_cnt++;
      $display("watchdog expired");
      test_done();
   end

   initial begin
      error_cnt = 0;
      comparisons = 0;
      rst = 1'b1;
      isa_mode_select = 1'b0;
      test_mode_n = 1'b1;
      irq_ext = '0;
      irq_int = '0;
      bus_on = 1'b0;
      bus_word = 16'h0000;
      rf_wr = '0;
      rf_rd = '0;
      step(3);
      chk_bit("emu_mode", 1'b0, emu_mode);
      chk_bit("fei_o", 1'b1, fei_o);
      rst = 1'b0;
      step(4);
      t_pins();
      t_clocks();
      t_regs();
      t_native();
      t_irq();
      t_emu();
      test_done();
   end
endmodule : processor_mode_status_pins_bench
